// file: include/apgsw_pkg.sv
// Constants shared by the auxiliary pin and serial wiring block
package apgsw_pkg;
  // Register data width and serial address width
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 6;

  // Register addresses
  localparam logic [5:0] ADDR_CONFIG  = 6'h0D;  // Pin function setup
  localparam logic [5:0] ADDR_CONTROL = 6'h0E;  // Pin levels

  // Command byte layout
  localparam int unsigned CMD_WRITE_BIT = 7;    // 1 = write
  localparam int unsigned CMD_INCR_BIT  = 6;    // 1 = auto increment

  // Config register fields
  localparam int unsigned CFG_XTAL_GPIO = 7;    // Crystal pin as GPIO
  localparam int unsigned CFG_INTERRUPT_POLARITY   = 6;    // Interrupt active high
  localparam int unsigned CFG_SDO_OD    = 5;    // Data-out pin open drain
  localparam int unsigned CFG_XTAL_OD   = 4;    // Crystal pin open drain
  localparam int unsigned CFG_AMP_OD    = 3;    // Amp pin open drain
  localparam int unsigned CFG_AMP_GPIO  = 2;    // Amp pin as GPIO
  localparam int unsigned CFG_THREE_W   = 1;    // Three-wire serial
  localparam int unsigned CFG_IRQ_GPIO  = 0;    // Interrupt pin as GPIO

  // Control register fields
  localparam int unsigned CTL_XTAL_OUT  = 7;
  localparam int unsigned CTL_SDO_OUT   = 6;
  localparam int unsigned CTL_AMP_OUT   = 5;
  localparam int unsigned CTL_IRQ_OUT   = 4;
  localparam int unsigned CTL_XTAL_IN   = 3;
  localparam int unsigned CTL_SDO_IN    = 2;
  localparam int unsigned CTL_AMP_IN    = 1;
  localparam int unsigned CTL_IRQ_IN    = 0;
  localparam int unsigned CTL_OUT_LSB   = 4;
  localparam int unsigned CTL_OUT_W     = 4;

  // Reset values
  localparam logic [7:0] CONFIG_RESET   = 8'h00;
  localparam logic [3:0] CTL_OUT_RESET  = 4'h0;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // Input synchroniser lanes
  localparam int unsigned SYN_SCLK = 0;
  localparam int unsigned SYN_NSS  = 1;
  localparam int unsigned SYN_SHARED_SERIAL_DATA_PIN = 2;
  localparam int unsigned SYN_SDO  = 3;
  localparam int unsigned SYN_XTAL = 4;
  localparam int unsigned SYN_AMP  = 5;
  localparam int unsigned SYN_IRQ  = 6;
  localparam int unsigned SYN_W    = 7;
endpackage

// file: design/apgsw_spi_shift.sv
// Serial byte shifter, mode 0, most significant bit first
`timescale 1ns/10ps
module apgsw_spi_shift #(
  parameter int unsigned WIDTH = 8            // Bits per byte
) (
  input  wire logic             clock,        // System clock
  input  wire logic             rst_n,        // Synchronised reset
  input  wire logic             sclk_s,       // Synchronised serial clock
  input  wire logic             nss_n_s,      // Synchronised select
  input  wire logic             sin_s,        // Synchronised serial in
  input  wire logic [WIDTH-1:0] tx_byte,      // Next byte to send
  output logic      [WIDTH-1:0] rx_byte,      // Last byte received
  output logic                  rx_valid,     // Byte received pulse
  output logic                  sout          // Serial out bit
);
  localparam int unsigned CNT_W = $clog2(WIDTH);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(WIDTH - 1);

  logic             sclk_prev_ff;             // Clock one cycle back
  logic [CNT_W-1:0] cnt_ff;                   // Bit position in byte
  logic [WIDTH-1:0] rx_sh_ff;                 // Input shift register
  logic [WIDTH-1:0] tx_sh_ff;                 // Output shift register
  logic [WIDTH-1:0] rx_byte_ff;               // Captured byte
  logic             rx_valid_ff;              // Capture pulse
  logic             rise;                     // Serial clock rising
  logic             fall;                     // Serial clock falling

  assign rise = sclk_s & ~sclk_prev_ff;
  assign fall = ~sclk_s & sclk_prev_ff;

  // Edge history of the serial clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_s;
    end
  end

  // Sample on rising edge, count bits, flag a full byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff      <= '0;
      rx_sh_ff    <= '0;
      rx_byte_ff  <= '0;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (nss_n_s) begin
        // Deselect restarts byte framing
        cnt_ff <= '0;
      end else if (rise) begin
        rx_sh_ff <= {rx_sh_ff[WIDTH-2:0], sin_s};
        if (cnt_ff == LAST) begin
          cnt_ff      <= '0;
          rx_byte_ff  <= {rx_sh_ff[WIDTH-2:0], sin_s};
          rx_valid_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
  end

  // Shift out on falling edge, load a new byte at a byte boundary
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_ff <= '0;
    end else if (nss_n_s) begin
      tx_sh_ff <= '0;
    end else if (fall) begin
      if (cnt_ff == '0) begin
        tx_sh_ff <= tx_byte;
      end else begin
        tx_sh_ff <= {tx_sh_ff[WIDTH-2:0], 1'b0};
      end
    end
  end

  assign rx_byte  = rx_byte_ff;
  assign rx_valid = rx_valid_ff;
  assign sout     = tx_sh_ff[WIDTH-1];
endmodule

// file: design/apgsw_top.sv
// Auxiliary pin GPIO control and serial port wiring select
`timescale 1ns/10ps
module apgsw_top (
  input  wire logic clock,                    // 50 MHz system clock
  input  wire logic rst_n,                    // Async reset, active low
  input  wire logic spi_sclk,                 // Serial clock pin
  input  wire logic spi_nss_n,                // Serial select pin
  input  wire logic shared_serial_data_pin_i, // Serial in / shared data
  output logic      shared_serial_data_pin_o, // Shared data drive value
  output logic      shared_serial_data_pin_oe_n, // Low while driving
  input  wire logic sdo_pin_i,                // Data-out pin level
  output logic      sdo_pin_o,                // Data-out drive value
  output logic      sdo_pin_oe_n,             // Low while driving
  input  wire logic crystal_clock_out_pin_i,  // Crystal pin level
  output logic      crystal_clock_out_pin_o,  // Crystal drive value
  output logic      crystal_clock_out_pin_oe_n, // Low while driving
  input  wire logic power_amp_ctl_pin_i,      // Amp pin level
  output logic      power_amp_ctl_pin_o,      // Amp drive value
  output logic      power_amp_ctl_pin_oe_n,   // Low while driving
  input  wire logic irq_pin_i,                // Interrupt pin level
  output logic      irq_pin_o,                // Interrupt drive value
  output logic      irq_pin_oe_n,             // Low while driving
  input  wire logic crystal_func_level,       // Clock output from core
  input  wire logic amp_func_level,           // Amp control from core
  input  wire logic irq_func_level            // Interrupt request, high
);
  typedef enum logic [0:0] {
    ST_CMD,                                   // Expect command byte
    ST_DATA                                   // Data bytes follow
  } apgsw_state_e;

  localparam int unsigned DW = apgsw_pkg::DATA_W;

  logic [1:0]                      rst_sync_ff;  // Reset release chain
  logic                            rst_n_s;      // Synchronised reset
  logic [apgsw_pkg::SYN_W-1:0]     syn_raw;      // Raw pin inputs
  logic [apgsw_pkg::SYN_W-1:0]     syn1_ff;      // First sync stage
  logic [apgsw_pkg::SYN_W-1:0]     syn2_ff;      // Second sync stage
  apgsw_state_e                    state_ff;     // Transaction phase
  logic                            write_ff;     // Transaction writes
  logic                            incr_ff;      // Address increments
  logic [apgsw_pkg::ADDR_W-1:0]    addr_ff;      // Current address
  logic [DW-1:0]                   config_ff;    // Pin function setup
  logic [apgsw_pkg::CTL_OUT_W-1:0] gpio_out_ff;  // GPIO output levels
  logic [DW-1:0]                   rx_byte;      // Received byte
  logic                            rx_valid;     // Byte pulse
  logic                            sout;         // Serial out bit
  logic                            sin_s;        // Serial in, synced
  logic [DW-1:0]                   rd_data;      // Read mux
  logic                            three_wire;   // Wiring mode
  logic                            selected;     // Select asserted
  logic                            reading;      // Read data phase

  // Reset is released through two flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_ff[1];

  // Gather every pin input for synchronising
  always_comb begin
    syn_raw                       = '0;
    syn_raw[apgsw_pkg::SYN_SCLK]  = spi_sclk;
    syn_raw[apgsw_pkg::SYN_NSS]   = spi_nss_n;
    syn_raw[apgsw_pkg::SYN_SHARED_SERIAL_DATA_PIN]  = shared_serial_data_pin_i;
    syn_raw[apgsw_pkg::SYN_SDO]   = sdo_pin_i;
    syn_raw[apgsw_pkg::SYN_XTAL]  = crystal_clock_out_pin_i;
    syn_raw[apgsw_pkg::SYN_AMP]   = power_amp_ctl_pin_i;
    syn_raw[apgsw_pkg::SYN_IRQ]   = irq_pin_i;
  end

  // Two-stage synchroniser per pin
  genvar g;
  generate
    for (g = 0; g < apgsw_pkg::SYN_W; g++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
          syn1_ff[g] <= (g == apgsw_pkg::SYN_NSS);
          syn2_ff[g] <= (g == apgsw_pkg::SYN_NSS);
        end else begin
          syn1_ff[g] <= syn_raw[g];
          syn2_ff[g] <= syn1_ff[g];
        end
      end
    end
  endgenerate

  assign three_wire = config_ff[apgsw_pkg::CFG_THREE_W];
  assign selected   = ~syn2_ff[apgsw_pkg::SYN_NSS];
  // Serial input is always the shared data line
  assign sin_s      = syn2_ff[apgsw_pkg::SYN_SHARED_SERIAL_DATA_PIN];
  assign reading    = selected & (state_ff == ST_DATA) & ~write_ff;

  apgsw_spi_shift #(
    .WIDTH    (DW)
  ) u_shift (
    .clock    (clock),
    .rst_n    (rst_n_s),
    .sclk_s   (syn2_ff[apgsw_pkg::SYN_SCLK]),
    .nss_n_s  (syn2_ff[apgsw_pkg::SYN_NSS]),
    .sin_s    (sin_s),
    .tx_byte  (rd_data),
    .rx_byte  (rx_byte),
    .rx_valid (rx_valid),
    .sout     (sout)
  );

  // Register read mux; input bits show sensed pin levels
  always_comb begin
    rd_data = apgsw_pkg::UNMAPPED_READ;
    if (addr_ff == apgsw_pkg::ADDR_CONFIG) begin
      rd_data = config_ff;
    end else if (addr_ff == apgsw_pkg::ADDR_CONTROL) begin
      rd_data[apgsw_pkg::CTL_OUT_LSB +: apgsw_pkg::CTL_OUT_W] = gpio_out_ff;
      rd_data[apgsw_pkg::CTL_XTAL_IN] = syn2_ff[apgsw_pkg::SYN_XTAL];
      rd_data[apgsw_pkg::CTL_SDO_IN]  = syn2_ff[apgsw_pkg::SYN_SDO];
      rd_data[apgsw_pkg::CTL_AMP_IN]  = syn2_ff[apgsw_pkg::SYN_AMP];
      rd_data[apgsw_pkg::CTL_IRQ_IN]  = syn2_ff[apgsw_pkg::SYN_IRQ];
    end
  end

  // Transaction phase: command byte then data bytes
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_ff <= ST_CMD;
      write_ff <= 1'b0;
      incr_ff  <= 1'b0;
      addr_ff  <= '0;
    end else if (!selected) begin
      state_ff <= ST_CMD;
    end else if (rx_valid) begin
      unique case (state_ff)
        ST_CMD: begin
          write_ff <= rx_byte[apgsw_pkg::CMD_WRITE_BIT];
          incr_ff  <= rx_byte[apgsw_pkg::CMD_INCR_BIT];
          addr_ff  <= rx_byte[apgsw_pkg::ADDR_W-1:0];
          state_ff <= ST_DATA;
        end
        ST_DATA: begin
          // Each data byte advances the address when asked
          if (incr_ff) begin
            addr_ff <= addr_ff + 1'b1;
          end
        end
      endcase
    end
  end

  // Config register write
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      config_ff <= apgsw_pkg::CONFIG_RESET;
    end else if (rx_valid && state_ff == ST_DATA && write_ff &&
                 addr_ff == apgsw_pkg::ADDR_CONFIG) begin
      config_ff <= rx_byte;
    end
  end

  // Output bits of the control register; input bits ignore writes
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      gpio_out_ff <= apgsw_pkg::CTL_OUT_RESET;
    end else if (rx_valid && state_ff == ST_DATA && write_ff &&
                 addr_ff == apgsw_pkg::ADDR_CONTROL) begin
      gpio_out_ff <= rx_byte[apgsw_pkg::CTL_OUT_LSB +: apgsw_pkg::CTL_OUT_W];
    end
  end

  // Pin drivers, registered; open drain drives only a low level
  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      shared_serial_data_pin_o    <= 1'b0;
      shared_serial_data_pin_oe_n <= 1'b1;
      sdo_pin_o                   <= 1'b0;
      sdo_pin_oe_n                <= 1'b1;
      crystal_clock_out_pin_o     <= 1'b0;
      crystal_clock_out_pin_oe_n  <= 1'b1;
      power_amp_ctl_pin_o         <= 1'b0;
      power_amp_ctl_pin_oe_n      <= 1'b1;
      irq_pin_o                   <= 1'b0;
      irq_pin_oe_n                <= 1'b1;
    end else begin
      // Shared data pin turns around only in three-wire reads
      shared_serial_data_pin_o    <= sout;
      shared_serial_data_pin_oe_n <= ~(three_wire & reading);
      if (three_wire) begin
        // Data-out pin released to GPIO use
        sdo_pin_o    <= gpio_out_ff[apgsw_pkg::CTL_SDO_OUT -
                                    apgsw_pkg::CTL_OUT_LSB];
        sdo_pin_oe_n <= config_ff[apgsw_pkg::CFG_SDO_OD] &
                        gpio_out_ff[apgsw_pkg::CTL_SDO_OUT -
                                    apgsw_pkg::CTL_OUT_LSB];
      end else begin
        // Four-wire slave drives data out while selected
        sdo_pin_o    <= sout;
        sdo_pin_oe_n <= ~selected;
      end
      if (config_ff[apgsw_pkg::CFG_XTAL_GPIO]) begin
        crystal_clock_out_pin_o    <= gpio_out_ff[apgsw_pkg::CTL_XTAL_OUT -
                                      apgsw_pkg::CTL_OUT_LSB];
        crystal_clock_out_pin_oe_n <= config_ff[apgsw_pkg::CFG_XTAL_OD] &
                                      gpio_out_ff[apgsw_pkg::CTL_XTAL_OUT -
                                      apgsw_pkg::CTL_OUT_LSB];
      end else begin
        crystal_clock_out_pin_o    <= crystal_func_level;
        crystal_clock_out_pin_oe_n <= 1'b0;
      end
      if (config_ff[apgsw_pkg::CFG_AMP_GPIO]) begin
        power_amp_ctl_pin_o    <= gpio_out_ff[apgsw_pkg::CTL_AMP_OUT -
                                  apgsw_pkg::CTL_OUT_LSB];
        power_amp_ctl_pin_oe_n <= config_ff[apgsw_pkg::CFG_AMP_OD] &
                                  gpio_out_ff[apgsw_pkg::CTL_AMP_OUT -
                                  apgsw_pkg::CTL_OUT_LSB];
      end else begin
        power_amp_ctl_pin_o    <= amp_func_level;
        power_amp_ctl_pin_oe_n <= 1'b0;
      end
      if (config_ff[apgsw_pkg::CFG_IRQ_GPIO]) begin
        // Interrupt GPIO is always open drain
        irq_pin_o    <= gpio_out_ff[apgsw_pkg::CTL_IRQ_OUT -
                                    apgsw_pkg::CTL_OUT_LSB];
        irq_pin_oe_n <= gpio_out_ff[apgsw_pkg::CTL_IRQ_OUT -
                                    apgsw_pkg::CTL_OUT_LSB];
      end else begin
        // Polarity bit set gives active high request
        irq_pin_o    <= ~(irq_func_level ^ config_ff[apgsw_pkg::CFG_INTERRUPT_POLARITY]);
        irq_pin_oe_n <= 1'b0;
      end
    end
  end
endmodule

// file: testbench/apgsw_monitor.sv
// Checker for pin drive levels and serial data turnaround
`timescale 1ns/10ps
module apgsw_monitor (
  input wire logic clock,                       // System clock
  input wire logic rst_n,                       // Reset, active low
  input wire logic spi_sclk,                    // Serial clock
  input wire logic spi_nss_n,                   // Serial select
  input wire logic shared_serial_data_pin_o,    // Shared data value
  input wire logic shared_serial_data_pin_oe_n, // Shared data enable
  input wire logic sdo_pin_oe_n,                // Data-out enable
  input wire logic crystal_clock_out_pin_o,     // Crystal value
  input wire logic crystal_clock_out_pin_oe_n,  // Crystal enable
  input wire logic power_amp_ctl_pin_o,         // Amp value
  input wire logic power_amp_ctl_pin_oe_n,      // Amp enable
  input wire logic irq_pin_o,                   // Interrupt value
  input wire logic irq_pin_oe_n,                // Interrupt enable
  input wire logic crystal_func_level,          // Core clock level
  input wire logic amp_func_level,              // Core amp level
  input wire logic irq_func_level               // Core request level
);
  logic [2:0] rdy_cnt_ff;  // Cycles since reset release
  logic [3:0] idle_cnt_ff; // Cycles with select high
  logic       rdy;         // Pins carry function values
  logic [2:0] funcs;       // Core levels together
  logic [2:0] pins;        // Pin values together
  logic       quiet;       // All pins released; crystal, amp, interrupt values low
  assign rdy   = (rdy_cnt_ff == 3'h4);
  assign funcs = {crystal_func_level, amp_func_level, irq_func_level};
  assign pins  = {crystal_clock_out_pin_o, power_amp_ctl_pin_o, irq_pin_o};
  assign quiet = crystal_clock_out_pin_oe_n & power_amp_ctl_pin_oe_n &
                 irq_pin_oe_n & sdo_pin_oe_n & shared_serial_data_pin_oe_n &
                 ~(|pins);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Count settle time after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdy_cnt_ff <= 3'h0;
    end else if (!rdy) begin
      rdy_cnt_ff <= rdy_cnt_ff + 3'h1;
    end
  end
  // Count idle cycles between frames
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_ff <= 4'h0;
    end else if (!spi_nss_n) begin
      idle_cnt_ff <= 4'h0;
    end else if (idle_cnt_ff != 4'hF) begin
      idle_cnt_ff <= idle_cnt_ff + 4'h1;
    end
  end
  // Deselect followed by release of the shared line
  sequence s_deselect;
    $rose(spi_nss_n);
  endsequence
  sequence s_line_free;
    ##[0:8] shared_serial_data_pin_oe_n;
  endsequence
  xtal_release_a: assert property (
    rdy && crystal_clock_out_pin_oe_n |-> crystal_clock_out_pin_o)
    else $error("crystal pin released with low value");
  amp_release_a: assert property (
    rdy && power_amp_ctl_pin_oe_n |-> power_amp_ctl_pin_o)
    else $error("amp pin released with low value");
  irq_release_a: assert property (
    rdy && irq_pin_oe_n |-> irq_pin_o)
    else $error("interrupt pin released with low value");
  pin_hold_a: assert property (
    rdy && idle_cnt_ff > 4'h3 && $stable(funcs) |=> $stable(pins))
    else $error("pin changed with no cause");
  reset_quiet_a: assert property (
    $rose(rst_n) |-> quiet [*2])
    else $error("pin active right after reset");
  line_free_a: assert property (
    s_deselect |-> s_line_free)
    else $error("shared line still driven after deselect");
  line_drive_a: assert property (
    $fell(shared_serial_data_pin_oe_n) |-> !spi_nss_n && !$past(spi_nss_n, 8))
    else $error("shared line driven outside data phase");
  sdo_free_a: assert property (
    !shared_serial_data_pin_oe_n |=> $stable(sdo_pin_oe_n))
    else $error("data-out pin moved during three-wire read");
  shift_edge_a: assert property (
    !shared_serial_data_pin_oe_n && $changed(shared_serial_data_pin_o)
      |-> !spi_sclk)
    else $error("shared data changed while clock high");
endmodule
bind apgsw_top apgsw_monitor u_mon (
  .clock, .rst_n, .spi_sclk, .spi_nss_n, .shared_serial_data_pin_o,
  .shared_serial_data_pin_oe_n, .sdo_pin_oe_n, .crystal_clock_out_pin_o,
  .crystal_clock_out_pin_oe_n, .power_amp_ctl_pin_o, .power_amp_ctl_pin_oe_n,
  .irq_pin_o, .irq_pin_oe_n, .crystal_func_level, .amp_func_level,
  .irq_func_level
);

// file: testbench/apgsw_host_model.sv
// Serial host model driving the pin block's slave port
`timescale 1ns/10ps
module apgsw_host_model (
  input  wire logic clock,   // System clock
  input  wire logic three_w, // One shared data line in use
  input  wire logic miso,    // Resolved return data line
  output logic      sclk,    // Serial clock, still outside frames
  output logic      nss_n,   // Select, active low
  output logic      mosi,    // Host data bit
  output logic      mosi_oe  // High while host drives data
);
  localparam int HALF = 10;  // Clocks per serial half period
  initial begin
    sclk = 1'h0;
    nss_n = 1'h1;
    mosi = 1'h0;
    mosi_oe = 1'h0;
  end
  // One byte, data set on falling edge, return sampled on rising edge;
  // rel hands the shared line over once the last bit has been taken
  task automatic xbyte(input logic [7:0] tx, input logic rel,
                       output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clock);
      sclk <= 1'h0;
      mosi <= tx[i];
      repeat (HALF - 1) @(posedge clock);
      sclk <= 1'h1;
      rx[i] = miso;
      repeat (4) @(posedge clock);
      if (rel && i == 0) begin
        // Let go before the slave turns the line around
        mosi_oe <= 1'h0;
      end
      repeat (HALF - 5) @(posedge clock);
    end
  endtask
  // Command byte then one data byte; three-wire reads free the shared line
  task automatic frame(input logic wr, input logic [5:0] addr,
                       input logic [7:0] wdat, output logic [7:0] rdat);
    logic [7:0] junk;
    @(posedge clock);
    nss_n <= 1'h0;
    mosi_oe <= 1'h1;
    xbyte({wr, 1'h0, addr}, three_w && !wr, junk);
    xbyte(wdat, 1'h0, rdat);
    @(posedge clock);
    sclk <= 1'h0;
    nss_n <= 1'h1;
    mosi_oe <= 1'h0;
    repeat (HALF) @(posedge clock);
  endtask
endmodule

// file: testbench/tb_top.sv
// Testbench for the auxiliary pin and serial wiring block
`timescale 1ns/10ps
module tb_top;
  logic       clock, rst_n, spi_sclk, spi_nss_n; // Clock, reset, serial
  logic       host_mosi, host_oe, three_w, host_miso; // Host data side
  logic [3:0] ext_lvl;                           // Outside pull levels
  logic       crystal_func_level, amp_func_level, irq_func_level;
  logic       shared_serial_data_pin_o, shared_serial_data_pin_oe_n;
  logic       sdo_pin_o, sdo_pin_oe_n, irq_pin_o, irq_pin_oe_n;
  logic       crystal_clock_out_pin_o, crystal_clock_out_pin_oe_n;
  logic       power_amp_ctl_pin_o, power_amp_ctl_pin_oe_n;
  logic       shared_serial_data_pin_i, sdo_pin_i, irq_pin_i;
  logic       crystal_clock_out_pin_i, power_amp_ctl_pin_i;
  int         n_mismatch, n_compared, cycles; // Counters
  // Each pin shows its driver, else the outside pull level; shared data falls back to host data or high
  assign crystal_clock_out_pin_i = crystal_clock_out_pin_oe_n ?
                                   ext_lvl[3] : crystal_clock_out_pin_o;
  assign sdo_pin_i = sdo_pin_oe_n ? ext_lvl[2] : sdo_pin_o;
  assign power_amp_ctl_pin_i = power_amp_ctl_pin_oe_n ?
                               ext_lvl[1] : power_amp_ctl_pin_o;
  assign irq_pin_i = irq_pin_oe_n ? ext_lvl[0] : irq_pin_o;
  assign shared_serial_data_pin_i = !shared_serial_data_pin_oe_n ?
    shared_serial_data_pin_o : (host_oe ? host_mosi : 1'h1);
  assign host_miso = three_w ? shared_serial_data_pin_i : sdo_pin_i;
  apgsw_top uut (
    .clock, .rst_n, .spi_sclk, .spi_nss_n, .shared_serial_data_pin_i,
    .shared_serial_data_pin_o, .shared_serial_data_pin_oe_n, .sdo_pin_i,
    .sdo_pin_o, .sdo_pin_oe_n, .crystal_clock_out_pin_i,
    .crystal_clock_out_pin_o, .crystal_clock_out_pin_oe_n,
    .power_amp_ctl_pin_i, .power_amp_ctl_pin_o, .power_amp_ctl_pin_oe_n,
    .irq_pin_i, .irq_pin_o, .irq_pin_oe_n, .crystal_func_level,
    .amp_func_level, .irq_func_level
  );
  apgsw_host_model host (
    .clock, .three_w, .miso(host_miso), .sclk(spi_sclk),
    .nss_n(spi_nss_n), .mosi(host_mosi), .mosi_oe(host_oe)
  );
  always #10 clock = ~clock;
  // Compare one value and count it
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Register write and checked register read
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] junk;
    host.frame(1'h1, a, d, junk);
  endtask
  task automatic rd_chk(input string what, input logic [5:0] a,
                        input logic [7:0] exp);
    logic [7:0] v;
    host.frame(1'h0, a, 8'h00, v);
    check(what, v, exp);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    clock = 1'h0;
    rst_n = 1'h0;
    ext_lvl = 4'hF;
    three_w = 1'h0;
    crystal_func_level = 1'h1;
    amp_func_level = 1'h0;
    irq_func_level = 1'h0;
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'h1;
    repeat (8) @(posedge clock);
    // Defaults and four-wire read back
    rd_chk("config reset", 6'h0D, 8'h00);
    rd_chk("control reset", 6'h0E, 8'h09);
    rd_chk("unmapped", 6'h3F, 8'h00);
    $display("test defaults done");
    // GPIO outputs override core levels; crystal and amp push-pull, interrupt open drain
    wr(6'h0D, 8'h85);
    crystal_func_level <= 1'h0;
    amp_func_level <= 1'h1;
    wr(6'h0E, 8'hA0);
    check("xtal out", crystal_clock_out_pin_o, 1'h1);
    check("xtal oe_n", crystal_clock_out_pin_oe_n, 1'h0);
    check("amp out", power_amp_ctl_pin_o, 1'h1);
    check("irq oe_n", irq_pin_oe_n, 1'h0);
    check("irq out", irq_pin_o, 1'h0);
    wr(6'h0E, 8'h5F);
    ext_lvl <= 4'hE;
    rd_chk("inputs low", 6'h0E, 8'h50);
    ext_lvl <= 4'hF;
    rd_chk("irq in high", 6'h0E, 8'h51);
    $display("test gpio outputs done");
    // Open drain released pins read as inputs
    wr(6'h0D, 8'h9D);
    wr(6'h0E, 8'hB0);
    ext_lvl <= 4'h2;
    check("xtal released", crystal_clock_out_pin_oe_n, 1'h1);
    rd_chk("od inputs a", 6'h0E, 8'hB2);
    ext_lvl <= 4'hD;
    rd_chk("od inputs b", 6'h0E, 8'hB9);
    $display("test gpio inputs done");
    // Three-wire wiring frees the data-out pin
    wr(6'h0D, 8'h22);
    three_w <= 1'h1;
    wr(6'h0E, 8'h40);
    ext_lvl <= 4'hB;
    check("sdo released", sdo_pin_oe_n, 1'h1);
    rd_chk("three wire a", 6'h0E, 8'h43);
    ext_lvl <= 4'hF;
    rd_chk("three wire b", 6'h0E, 8'h47);
    wr(6'h0E, 8'h00);
    check("sdo oe_n", sdo_pin_oe_n, 1'h0);
    check("sdo out", sdo_pin_o, 1'h0);
    wr(6'h0D, 8'h00);
    three_w <= 1'h0;
    rd_chk("four wire back", 6'h0D, 8'h00);
    $display("test wiring done");
    report_and_stop();
  end
endmodule
